// ### rtl/charge_setpoint_decoder.sv
// charge setpoint decoder: wishbone registers, setpoints, switches, relearn
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE1 - voltage word counts millivolts
// RULE2 - drop four lsbs, eleven bits drive dac
// RULE3 - clamp voltage request above 19.200 V
// RULE4 - below 1.024 V gives zero, stops charging
// RULE5 - voltage limit input caps programmed voltage
// RULE6 - current word counts milliamperes
// RULE7 - drop seven lsbs, six bits drive dac
// RULE8 - clamp current request above 8.064 A
// RULE9 - small nonzero current raised to 128 mA
// RULE10 - current defaults to 128 mA at reset
// RULE11 - current limit input caps programmed current
// RULE12 - current loop until setpoint, then voltage loop
// RULE13 - source overload reduces charge current
// RULE14 - adapter presence selects source and load switches
// RULE15 - host relearn: isolate, discharge, then recharge
// RULE16 - status bit 15 shows adapter present
// RULE17 - status bit 14 shows battery present
// RULE18 - power fail: source off, bit 13 set
// RULE19 - undervoltage caps compliance at 128 mA
// RULE20 - zero current word gives zero current
module charge_setpoint_decoder
  import charge_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // analog condition comparators, asynchronous
  input  wire logic        adapter_present_flag_i,
  input  wire logic        power_fail_i,
  input  wire logic        thermistor_input_i,
  input  wire logic        battery_uv_i,
  input  wire logic        battery_sense_at_setpoint_i,
  input  wire logic        source_current_loop_i,
  input  wire logic        battery_empty_i,
  input  wire logic        loop_tick_i,
  // digitised limit inputs, in dac units, asynchronous
  input  wire logic [10:0] voltage_limit_input_i,
  input  wire logic [5:0]  current_limit_input_i,
  // setpoint dacs
  output logic      [10:0] voltage_dac_o,
  output logic      [5:0]  current_dac_o,
  output logic             charge_enable_o,
  // power path switches, high turns the switch on
  output logic             source_switch_drive_o,
  output logic             load_switch_drive_o,
  // which loop holds control
  output logic             voltage_loop_o,
  output logic             charge_current_loop_o,
  output logic             source_current_loop_o
);

`include "charge_params.svh"

  localparam int NPIN = $bits(pins_s);
  localparam int NLIM = $bits(limits_s);

  state_s      st_r;
  state_s      st_nxt;
  pins_s       pins;
  limits_s     lims;
  logic [10:0] vcode;
  logic [5:0]  icode;
  logic        vzero;

  pin_sync3 #(
    .W       (NPIN)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({adapter_present_flag_i, power_fail_i, thermistor_input_i,
               battery_uv_i, battery_sense_at_setpoint_i,
               source_current_loop_i, battery_empty_i, loop_tick_i}),
    .level_o (pins)
  );

  // limit codes are slow analog values; per-bit agreement is enough
  pin_sync3 #(
    .W       (NLIM)
  ) u_lim_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({voltage_limit_input_i, current_limit_input_i}),
    .level_o (lims)
  );

  setpoint_calc u_calc (
    .volt_word_i (st_r.volt_word),
    .curr_word_i (st_r.curr_word),
    .lim_i       (lims),
    .battery_sense_uv_i   (pins.battery_sense_uv),
    .throttle_i  (st_r.throttle),
    .vcode_o     (vcode),
    .icode_o     (icode),
    .vzero_o     (vzero)
  );

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = dat[7:0];
    if (sel[1])
      r[15:8] = dat[15:8];
    return r;
  endfunction : merge16

  logic        req;
  logic        wr;
  logic        tick;
  logic        discharging;
  logic [15:0] status;

  always_comb
  begin
    st_nxt      = st_r;
    req         = wb_cyc_i && wb_stb_i;
    // writes land at the edge where the master samples ack
    wr          = req && wb_we_i && st_r.wb_ack;
    tick        = pins.loop_tick && !st_r.tick_prev;
    discharging = (st_r.relearn == RL_DISCHARGE);

    status                = 16'h0000;
    status[`ST_ADAPTER]   = pins.adapter_ok;                // RULE16
    status[`ST_BATTERY]   = pins.battery_sense_present;              // RULE17
    status[`ST_PWR_FAIL]  = pins.power_fail;                // RULE18
    status[`ST_RELEARN]   = (st_r.relearn != RL_IDLE);
    status[`ST_CHARGING]  = st_r.charge_en;
    status[`ST_SRC_LOOP]  = st_r.sloop;
    status[`ST_CUR_LOOP]  = st_r.iloop;
    status[`ST_VOLT_LOOP] = st_r.vloop;

    // bus slave: ack one cycle after the request, dropped the next
    st_nxt.wb_ack = req && !st_r.wb_ack;
    st_nxt.wb_dat = 32'h0000_0000;
    if (req && !st_r.wb_ack && !wb_we_i)
    begin
      case (wb_adr_i)
        `REG_VOLT:  st_nxt.wb_dat = {16'h0000, st_r.volt_word};
        `REG_CURR:  st_nxt.wb_dat = {16'h0000, st_r.curr_word};
        `REG_INCUR: st_nxt.wb_dat = {16'h0000, st_r.incur_word};
        `REG_STAT:  st_nxt.wb_dat = {16'h0000, status};
        `REG_CTRL:  st_nxt.wb_dat = {31'h0000_0000,
                                     st_r.relearn != RL_IDLE};
        default:    st_nxt.wb_dat = 32'h0000_0000;
      endcase
    end

    if (wr)
    begin
      case (wb_adr_i)
        `REG_VOLT:
          st_nxt.volt_word = merge16(st_r.volt_word, wb_dat_i, wb_sel_i);
        `REG_CURR:
          st_nxt.curr_word = merge16(st_r.curr_word, wb_dat_i, wb_sel_i);
        `REG_INCUR:
          st_nxt.incur_word = merge16(st_r.incur_word, wb_dat_i, wb_sel_i);
        default:
          st_nxt.volt_word = st_r.volt_word;
      endcase
    end

    // relearn sequence; abort wins over start in the same write
    case (st_r.relearn)
      RL_IDLE:
        if (wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] &&
            wb_dat_i[`CTRL_RELEARN] && !wb_dat_i[`CTRL_ABORT] &&
            pins.adapter_ok && pins.battery_sense_present)
          st_nxt.relearn = RL_DISCHARGE;                    // RULE15
      RL_DISCHARGE:
        if (pins.battery_sense_empty)
          st_nxt.relearn = RL_RECHARGE;                     // RULE15
      RL_RECHARGE:
        if (pins.at_setpoint)
          st_nxt.relearn = RL_IDLE;                         // RULE15
      default:
        st_nxt.relearn = RL_IDLE;
    endcase
    if (st_r.relearn != RL_IDLE &&
        (!pins.battery_sense_present ||
         (wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] &&
          wb_dat_i[`CTRL_ABORT])))
      st_nxt.relearn = RL_IDLE;

    // throttle steps on each loop tick: up while overloaded, else down
    st_nxt.tick_prev = pins.loop_tick;
    if (tick)
    begin
      if (pins.source_over && st_r.throttle != 6'h3F)
        st_nxt.throttle = st_r.throttle + 6'h01;            // RULE13
      else if (!pins.source_over && st_r.throttle != 6'h00)
        st_nxt.throttle = st_r.throttle - 6'h01;            // RULE13
    end

    // setpoints to the dacs
    st_nxt.vdac = vcode;
    st_nxt.idac = icode;
    st_nxt.charge_en = pins.adapter_ok && !pins.power_fail &&
                       pins.battery_sense_present && !vzero &&       // RULE4
                       (icode != 6'h00) && !discharging;    // RULE15

    // loop hand-over
    st_nxt.vloop = st_nxt.charge_en && pins.at_setpoint;    // RULE12
    st_nxt.iloop = st_nxt.charge_en && !pins.at_setpoint;   // RULE12
    st_nxt.sloop = st_nxt.charge_en && pins.source_over;    // RULE13

    // power path: adapter feeds the system, else the battery does
    if (pins.power_fail || !pins.adapter_ok)
    begin
      st_nxt.src_sw  = 1'b0;                                // RULE14 RULE18
      st_nxt.load_sw = 1'b1;                                // RULE14
    end
    else if (discharging)
    begin
      // battery isolated from the charger, drained into the load
      st_nxt.src_sw  = 1'b0;                                // RULE15
      st_nxt.load_sw = 1'b1;                                // RULE15
    end
    else
    begin
      st_nxt.src_sw  = 1'b1;                                // RULE14
      st_nxt.load_sw = 1'b0;                                // RULE14
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r            <= '0;
      st_r.volt_word  <= `VOLT_RESET;
      st_r.curr_word  <= `CURR_RESET;                       // RULE10
      st_r.incur_word <= `INCUR_RESET;
      st_r.relearn    <= RL_IDLE;
      st_r.load_sw    <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign wb_dat_o              = st_r.wb_dat;
  assign wb_ack_o              = st_r.wb_ack;
  assign voltage_dac_o         = st_r.vdac;
  assign current_dac_o         = st_r.idac;
  assign charge_enable_o       = st_r.charge_en;
  assign source_switch_drive_o = st_r.src_sw;
  assign load_switch_drive_o   = st_r.load_sw;
  assign voltage_loop_o        = st_r.vloop;
  assign charge_current_loop_o = st_r.iloop;
  assign source_current_loop_o = st_r.sloop;

endmodule : charge_setpoint_decoder
`default_nettype wire

// ### rtl/charge_params.svh
// constants for the charge setpoint decoder: offsets, fields, limits
`ifndef CHARGE_PARAMS_SVH
`define CHARGE_PARAMS_SVH

// register byte offsets on the wishbone bus
`define REG_VOLT        8'h00
`define REG_CURR        8'h04
`define REG_INCUR       8'h08
`define REG_STAT        8'h0C
`define REG_CTRL        8'h10

// reset values
`define VOLT_RESET      16'h0000
`define CURR_RESET      16'h0080
`define INCUR_RESET     16'h0100

// voltage word limits in millivolts
`define V_MAX_MV        16'h4B00
`define V_MIN_MV        16'h0400
`define V_MAX_CODE      11'h4B0

// current word limits in milliamperes
`define I_MAX_MA        16'h1F80
`define I_MIN_MA        16'h0080
`define I_MAX_CODE      6'h3F
`define I_MIN_CODE      6'h01

// status word fields
`define ST_ADAPTER      15
`define ST_BATTERY      14
`define ST_PWR_FAIL     13
`define ST_RELEARN      4
`define ST_CHARGING     3
`define ST_SRC_LOOP     2
`define ST_CUR_LOOP     1
`define ST_VOLT_LOOP    0

// control word fields
`define CTRL_RELEARN    0
`define CTRL_ABORT      1

`endif

// ### rtl/charge_pkg.sv
// types shared by the charge setpoint decoder
package charge_pkg;

  typedef enum logic [1:0] {
    RL_IDLE,
    RL_DISCHARGE,
    RL_RECHARGE
  } relearn_e;

  // synchronised pin conditions, one bit each
  typedef struct packed {
    logic adapter_ok;
    logic power_fail;
    logic battery_sense_present;
    logic battery_sense_uv;
    logic at_setpoint;
    logic source_over;
    logic battery_sense_empty;
    logic loop_tick;
  } pins_s;

  // limit codes already scaled into dac units
  typedef struct packed {
    logic [10:0] volt;
    logic [5:0]  curr;
  } limits_s;

  typedef struct packed {
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic [15:0] volt_word;
    logic [15:0] curr_word;
    logic [15:0] incur_word;
    relearn_e    relearn;
    logic [5:0]  throttle;
    logic        tick_prev;
    logic [10:0] vdac;
    logic [5:0]  idac;
    logic        charge_en;
    logic        src_sw;
    logic        load_sw;
    logic        vloop;
    logic        iloop;
    logic        sloop;
  } state_s;

endpackage : charge_pkg

// ### rtl/pin_sync3.sv
// three-stage input synchroniser, output follows when stages 2 and 3 agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // pins and result
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;

  sync_s        st_r;
  sync_s        st_nxt;
  logic [W-1:0] lvl_nxt;

  // each bit filtered on its own so a slow bit cannot hold back the rest
  for (genvar b = 0; b < W; b++)
  begin : g_bit
    assign lvl_nxt[b] = (st_r.s2[b] == st_r.s3[b]) ? st_r.s3[b]
                                                   : st_r.lvl[b];
  end

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.s1  = pin_i;
    st_nxt.s2  = st_r.s1;
    st_nxt.s3  = st_r.s2;
    st_nxt.lvl = lvl_nxt;
  end

  // one register process owns the whole state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level_o = st_r.lvl;

endmodule : pin_sync3
`default_nettype wire

// ### rtl/setpoint_calc.sv
// combinational decode of voltage and current words into dac codes
`timescale 1ns/1ns
`default_nettype none
module setpoint_calc
  import charge_pkg::*;
(
  // host words
  input  wire logic [15:0] volt_word_i,
  input  wire logic [15:0] curr_word_i,
  // limits and conditions
  input  wire limits_s     lim_i,
  input  wire logic        battery_sense_uv_i,
  input  wire logic [5:0]  throttle_i,
  // results
  output logic      [10:0] vcode_o,
  output logic      [5:0]  icode_o,
  output logic             vzero_o
);

`include "charge_params.svh"

  logic [10:0] v_raw;
  logic [5:0]  i_raw;
  logic [5:0]  i_lim;

  always_comb
  begin
    // one count is one millivolt; drop four lsbs
    v_raw   = volt_word_i[14:4];                       // RULE1 RULE2
    vzero_o = 1'b0;
    if (volt_word_i > `V_MAX_MV)
      v_raw = `V_MAX_CODE;                             // RULE3
    if (volt_word_i < `V_MIN_MV)
    begin
      v_raw   = 11'h000;                               // RULE4
      vzero_o = 1'b1;                                  // RULE4
    end
    vcode_o = (v_raw > lim_i.volt) ? lim_i.volt : v_raw; // RULE5

    // one count is one milliamp, 10 uV across the sense resistor
    i_raw = curr_word_i[12:7];                         // RULE6 RULE7
    if (curr_word_i > `I_MAX_MA)
      i_raw = `I_MAX_CODE;                             // RULE8
    else if (curr_word_i != 16'h0000 && curr_word_i <= `I_MIN_MA)
      i_raw = `I_MIN_CODE;                             // RULE9
    else if (curr_word_i == 16'h0000)
      i_raw = 6'h00;                                   // RULE20
    i_lim = (i_raw > lim_i.curr) ? lim_i.curr : i_raw; // RULE11
    // undervoltage caps compliance; the stored word is untouched
    if (battery_sense_uv_i && i_lim > `I_MIN_CODE)
      i_lim = `I_MIN_CODE;                             // RULE19
    // source-current throttle takes codes off the top
    icode_o = (i_lim > throttle_i) ? i_lim - throttle_i : 6'h00; // RULE13
  end

endmodule : setpoint_calc
`default_nettype wire

// ### tb/charge_env_model.sv
// battery pack and slow loop tick on the far side of the power path
`timescale 1ns/1ns
`default_nettype none
module charge_env_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // power path seen from the pack
  input  wire logic src_on_i,
  input  wire logic load_on_i,
  input  wire logic chg_en_i,
  input  wire logic slow_i,
  // pack state back to the block
  output logic      tick_o,
  output logic      empty_o,
  output logic      full_o
);
  logic [7:0] dis_r;
  logic [7:0] chg_r;
  wire  [7:0] dly = slow_i ? 8'h3C : 8'h0C;

  // free running tick, phase unrelated to clk_i
  initial
  begin
    tick_o = 1'b0;
    #7;
    forever #160 tick_o = ~tick_o;
  end

  // pack drains only while fed from itself through the load switch
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dis_r <= 8'h00;
      chg_r <= 8'h00;
    end
    else
    begin
      dis_r <= (load_on_i && !src_on_i) ? dis_r + {7'h00, dis_r != 8'hFF}
                                        : 8'h00;
      chg_r <= chg_en_i ? chg_r + {7'h00, chg_r != 8'hFF} : 8'h00;
    end
  end

  assign empty_o = dis_r >= dly;
  assign full_o  = chg_r >= dly;
endmodule : charge_env_model
`default_nettype wire

// ### tb/charge_setpoint_decoder_chk.sv
// port assertions for the charge setpoint decoder
`timescale 1ns/1ns
`default_nettype none
module charge_setpoint_decoder_chk (
  // clock, reset and bus handshake
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_ack_o,
  // conditions and limits
  input  wire logic        adapter_present_flag_i,
  input  wire logic        power_fail_i,
  input  wire logic        battery_uv_i,
  input  wire logic [10:0] voltage_limit_input_i,
  input  wire logic [5:0]  current_limit_input_i,
  // results
  input  wire logic [10:0] voltage_dac_o,
  input  wire logic [5:0]  current_dac_o,
  input  wire logic        charge_enable_o,
  input  wire logic        source_switch_drive_o,
  input  wire logic        load_switch_drive_o,
  input  wire logic        voltage_loop_o,
  input  wire logic        charge_current_loop_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence

  // six samples cover three or four sync stages plus the state register
  property p_ack; s_req |=> s_ack; endproperty
  property p_vtop; voltage_dac_o <= 11'h4B0; endproperty
  property p_izero; current_dac_o == 6'h00 |-> !charge_enable_o; endproperty
  property p_loops;
    (voltage_loop_o || charge_current_loop_o) == charge_enable_o &&
    !(voltage_loop_o && charge_current_loop_o);
  endproperty
  property p_swap; source_switch_drive_o != load_switch_drive_o; endproperty
  property p_noac;
    !adapter_present_flag_i [*6] |-> !source_switch_drive_o && !charge_enable_o;
  endproperty
  property p_pfail;
    power_fail_i [*6] |-> !source_switch_drive_o && !charge_enable_o;
  endproperty
  property p_uv; battery_uv_i [*6] |-> current_dac_o <= 6'h01; endproperty
  property p_icap;
    $stable(current_limit_input_i) [*6] |->
      current_dac_o <= current_limit_input_i;
  endproperty
  property p_vcap;
    $stable(voltage_limit_input_i) [*6] |->
      voltage_dac_o <= voltage_limit_input_i;
  endproperty

  a_ack: assert property (p_ack) else $error("bus ack timing");
  a_vtop: assert property (p_vtop) else $error("voltage over top");
  a_izero: assert property (p_izero) else $error("charging at zero");
  a_loops: assert property (p_loops) else $error("loop select");
  a_swap: assert property (p_swap) else $error("switch pair");
  a_noac: assert property (p_noac) else $error("no adapter path");
  a_pfail: assert property (p_pfail) else $error("power fail path");
  a_uv: assert property (p_uv) else $error("undervoltage cap");
  a_icap: assert property (p_icap) else $error("current cap");
  a_vcap: assert property (p_vcap) else $error("voltage cap");
endmodule : charge_setpoint_decoder_chk
bind charge_setpoint_decoder charge_setpoint_decoder_chk
  u_charge_setpoint_decoder_chk (.*);
`default_nettype wire

// ### tb/charge_setpoint_decoder_tb.sv
// self-checking bench for the charge setpoint decoder
`timescale 1ns/1ns
`default_nettype none
`include "charge_params.svh"
module charge_setpoint_decoder_tb;
  // bench signals carry the port names so the instance binds by name
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        adapter_present_flag_i, power_fail_i, thermistor_input_i;
  logic        battery_uv_i, battery_sense_at_setpoint_i, source_current_loop_i;
  logic        battery_empty_i, loop_tick_i, charge_enable_o;
  logic [10:0] voltage_limit_input_i, voltage_dac_o;
  logic [5:0]  current_limit_input_i, current_dac_o, base;
  logic        source_switch_drive_o, load_switch_drive_o, voltage_loop_o;
  logic        charge_current_loop_o, source_current_loop_o;
  logic [15:0] w;
  logic [15:0] vtab [6] = '{16'h0000, 16'h03FF, 16'h0400, 16'h4B00,
                            16'h4B01, 16'hFFFF};
  logic [15:0] itab [8] = '{16'h0000, 16'h0001, 16'h0080, 16'h0081,
                            16'h1F80, 16'h1F81, 16'hFFFF, 16'h0FFF};
  int          err_count, compares, ticks;

  charge_setpoint_decoder u_charge_setpoint_decoder (.*);
  charge_env_model u_charge_env_model (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .src_on_i  (source_switch_drive_o),
    .load_on_i (load_switch_drive_o),
    .chg_en_i  (charge_enable_o),
    .slow_i    (slow),
    .tick_o    (loop_tick_i),
    .empty_o   (battery_empty_i),
    .full_o    (battery_sense_at_setpoint_i)
  );

  always #20 clk_i = ~clk_i;

  // the whole sequence needs under 4000 cycles
  always @(posedge clk_i)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask : pause

  function automatic logic [10:0] vexp(input logic [15:0] v, input logic [10:0] c);
    logic [10:0] r;
    r = (v > 16'h4B00) ? 11'h4B0 : (v < 16'h0400) ? 11'h000 : v[14:4];
    return (r > c) ? c : r;
  endfunction : vexp

  function automatic logic [5:0] iexp(input logic [15:0] v, input logic [5:0] c);
    logic [5:0] r;
    r = (v == 16'h0000) ? 6'h00 : (v > 16'h1F80) ? 6'h3F
      : (v <= 16'h0080) ? 6'h01 : v[12:7];
    return (r > c) ? c : r;
  endfunction : iexp

  initial
  begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, power_fail_i, battery_uv_i} = 6'h00;
    {source_current_loop_i, slow, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {rst_i, adapter_present_flag_i, thermistor_input_i} = 3'h7;
    voltage_limit_input_i = 11'h7FF;
    current_limit_input_i = 6'h3F;
    void'($urandom(86017));
    pause(8);
    rst_i <= 1'b0;
    wb(1'b0, `REG_VOLT, 32'h0);
    chk("volt reset", 32'h0, q);
    wb(1'b0, `REG_CURR, 32'h0);
    chk("curr reset", 32'h80, q);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    pause(6);
    chk("idac reset", 32'h1, current_dac_o);
    for (int k = 0; k < 14; k++)
    begin
      w = (k < 6) ? vtab[k] : 16'($urandom);
      if (k > 9)
        voltage_limit_input_i <= 11'($urandom);
      wb(1'b1, `REG_VOLT, {16'h0, w});
      pause(6);
      chk("vdac", vexp(w, voltage_limit_input_i), voltage_dac_o);
      if (k < 6)
        chk("enable", w >= 16'h0400, charge_enable_o);
    end
    voltage_limit_input_i <= 11'h7FF;
    wb(1'b1, `REG_VOLT, 32'h3A98);
    for (int k = 0; k < 14; k++)
    begin
      w = (k < 8) ? itab[k] : 16'($urandom);
      if (k > 10)
        current_limit_input_i <= 6'($urandom);
      wb(1'b1, `REG_CURR, {16'h0, w});
      pause(6);
      chk("idac", iexp(w, current_limit_input_i), current_dac_o);
      if (w == 16'h0000)
        chk("zero enable", 32'h0, charge_enable_o);
    end
    current_limit_input_i <= 6'h3F;
    wb(1'b1, `REG_CURR, 32'h0FA0);
    base = iexp(16'h0FA0, 6'h3F);
    battery_uv_i <= 1'b1;
    pause(6);
    chk("uv idac", 32'h1, current_dac_o);
    wb(1'b0, `REG_CURR, 32'h0);
    chk("uv word", 32'h0FA0, q);
    battery_uv_i <= 1'b0;
    source_current_loop_i <= 1'b1;
    pause(100);
    chk("throttled", 32'h1, current_dac_o < base);
    chk("src loop on", 32'h1, source_current_loop_o);
    chk("loops on", 32'h2, {voltage_loop_o, charge_current_loop_o});
    source_current_loop_i <= 1'b0;
    pause(600);
    chk("recovered", base, current_dac_o);
    chk("src loop off", 32'h0, source_current_loop_o);
    wb(1'b0, `REG_STAT, 32'h0);
    chk("status", 32'hC000, q & 32'hE000);
    thermistor_input_i <= 1'b0;
    power_fail_i <= 1'b1;
    pause(6);
    chk("source off", 32'h0, source_switch_drive_o);
    wb(1'b0, `REG_STAT, 32'h0);
    chk("status fail", 32'hA000, q & 32'hE000);
    {thermistor_input_i, power_fail_i, adapter_present_flag_i} <= 3'h4;
    pause(6);
    chk("no adapter", 32'h1, {source_switch_drive_o, load_switch_drive_o});
    {adapter_present_flag_i, slow} <= 2'h3;
    pause(6);
    chk("adapter", 32'h2, {source_switch_drive_o, load_switch_drive_o});
    wb(1'b1, `REG_CTRL, 32'h1);
    pause(4);
    chk("relearn path", 32'h1, {source_switch_drive_o, load_switch_drive_o});
    wb(1'b0, `REG_CTRL, 32'h0);
    chk("relearn on", 32'h1, q[0]);
    for (int n = 0; n < 400 && source_switch_drive_o !== 1'b1; n++)
      @(posedge clk_i);
    chk("recharge path", 32'h1, source_switch_drive_o);
    chk("recharge loops", 32'h1, {voltage_loop_o, charge_current_loop_o});
    wb(1'b1, `REG_CTRL, 32'h1);
    wb(1'b1, `REG_CTRL, 32'h3);
    wb(1'b0, `REG_CTRL, 32'h0);
    chk("abort", 32'h0, q[0]);
    complete_run();
  end
endmodule : charge_setpoint_decoder_tb
`default_nettype wire
